// ===== hw/pcm_pkg.sv
// ============================================================
// Shared constants for the power clock manager
package pcm_pkg;

	// ============================================================
	// Sizes
	localparam int unsigned PERIPH_COUNT = 8;
	localparam int unsigned IRQ_COUNT    = 8;

	// ============================================================
	// Values after reset
	// Core clock runs out of reset so the core can fetch its reset vector
	localparam logic CORE_CLK_EN_RST   = 1'h1;
	// Peripherals start gated off to save power until software wants them
	localparam logic PERIPH_CLK_EN_RST = 1'h0;
	localparam logic PULSE_RST         = 1'h0;

	// ============================================================
	// Core clock states
	typedef enum logic [1:0] {
		PCM_CORE_RUN     = 2'b00,
		PCM_CORE_DRAIN   = 2'b01,
		PCM_CORE_STOPPED = 2'b10
	} pcm_core_state_type;

	localparam pcm_core_state_type CORE_STATE_RST = PCM_CORE_RUN;

endpackage : pcm_pkg

// ===== hw/pcm_clk_gate.sv
`timescale 1ns/1ps
// ============================================================
// Glitch-free clock gate
// Enable is retimed on the falling edge, so it only moves while the
// source clock is low and the AND can never cut a high pulse short.
module pcm_clk_gate #(
	parameter logic EN_RST = 1'h0
) (
	// Source clock and reset
	input  wire logic clk_in,
	input  wire logic rst_in,
	// Request for the clock to run
	input  wire logic enable_in,
	// Gated clock and its present state
	output      logic gclk_out,
	output      logic gate_open_out
);

	logic gate_open_r;

	// ============================================================
	// Enable retimed in the low phase
	always_ff @(negedge clk_in) begin
		if (rst_in) begin
			gate_open_r <= EN_RST;
		end else begin
			gate_open_r <= enable_in;
		end
	end

	// A clock cannot come straight from a flip-flop; this AND is the gate itself
	assign gclk_out      = clk_in & gate_open_r;
	assign gate_open_out = gate_open_r;

endmodule : pcm_clk_gate

// ===== hw/pcm_power_clock_manager.sv
`timescale 1ns/1ps
// Overview of operation
// - Core and every gated peripheral have their own software clock enable, each independent of the rest.
// - A request to stop the core clock lets the instruction in progress finish before the clock halts.
// - A stopped core clock restarts on any enabled interrupt request or on a hardware reset.
// - Turning a peripheral clock off stops it at once, with no wait for peripheral activity.
// - A peripheral whose clock returns carries on from the exact state it held when stopped.
// - Memory and register contents behind a stopped clock stay unchanged while it is stopped.
module pcm_power_clock_manager #(
	parameter int unsigned PERIPH_COUNT = pcm_pkg::PERIPH_COUNT,
	parameter int unsigned IRQ_COUNT    = pcm_pkg::IRQ_COUNT
) (
	// Master clock and device reset
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	// Software control of the core clock
	input  wire logic                    core_clk_off_in,
	// Instruction boundary from the core
	input  wire logic                    core_instr_done_in,
	// Interrupt requests and their enables
	input  wire logic [IRQ_COUNT-1:0]    irq_req_in,
	input  wire logic [IRQ_COUNT-1:0]    irq_enable_in,
	// Software control of peripheral clocks
	input  wire logic [PERIPH_COUNT-1:0] periph_clk_on_in,
	input  wire logic [PERIPH_COUNT-1:0] periph_clk_off_in,
	// Gated clocks
	output      logic                    core_gclk_out,
	output      logic [PERIPH_COUNT-1:0] periph_gclk_out,
	// Status towards software
	output      logic                    core_clk_running_out,
	output      logic                    core_stop_pending_out,
	output      logic                    core_wake_out,
	output      logic [IRQ_COUNT-1:0]    wake_cause_out,
	output      logic [PERIPH_COUNT-1:0] periph_clk_running_out
);

	// ============================================================
	// State
	pcm_pkg::pcm_core_state_type core_state_r;
	pcm_pkg::pcm_core_state_type core_state_nxt;
	logic [PERIPH_COUNT-1:0]     periph_en_r;
	logic [PERIPH_COUNT-1:0]     periph_en_nxt;
	logic                        core_wake_r;
	logic [IRQ_COUNT-1:0]        wake_cause_r;
	logic                        core_running_r;
	logic                        stop_pending_r;
	logic [PERIPH_COUNT-1:0]     periph_running_r;

	// ============================================================
	// Decode
	wire logic [IRQ_COUNT-1:0]    irq_active;
	wire logic                    wake_req;
	wire logic                    in_run;
	wire logic                    in_drain;
	wire logic                    in_stopped;
	wire logic                    drain_done;
	wire logic                    core_gate_req;
	wire logic                    core_gate_open;
	wire logic                    do_wake;
	wire logic [IRQ_COUNT-1:0]    wake_cause_nxt;
	wire logic                    stop_pending_nxt;
	// Gate states fed back for status
	wire logic [PERIPH_COUNT-1:0] periph_gate_open;

	assign irq_active = irq_req_in & irq_enable_in;
	assign wake_req   = |irq_active;
	assign in_run     = core_state_r == pcm_pkg::PCM_CORE_RUN;
	assign in_drain   = core_state_r == pcm_pkg::PCM_CORE_DRAIN;
	assign in_stopped = core_state_r == pcm_pkg::PCM_CORE_STOPPED;
	// Stop only once the core reports its current instruction retired
	assign drain_done = in_drain & core_instr_done_in;
	// Clock keeps running through DRAIN so the instruction can finish
	assign core_gate_req = ~in_stopped;
	assign do_wake       = in_stopped & wake_req;

	// Cause is held until the next wake so software may read it late
	assign wake_cause_nxt   = do_wake ? irq_active : wake_cause_r;
	assign stop_pending_nxt = core_state_nxt == pcm_pkg::PCM_CORE_DRAIN;

	// ============================================================
	// Core clock state machine
	always_comb begin
		core_state_nxt = core_state_r;
		case (core_state_r)
			pcm_pkg::PCM_CORE_RUN: begin
				if (core_clk_off_in) begin
					// Instruction that wrote the request may itself be retiring now
					if (core_instr_done_in) begin
						core_state_nxt = pcm_pkg::PCM_CORE_STOPPED;
					end else begin
						core_state_nxt = pcm_pkg::PCM_CORE_DRAIN;
					end
				end
			end
			pcm_pkg::PCM_CORE_DRAIN: begin
				if (drain_done) begin
					core_state_nxt = pcm_pkg::PCM_CORE_STOPPED;
				end
			end
			pcm_pkg::PCM_CORE_STOPPED: begin
				if (wake_req) begin
					core_state_nxt = pcm_pkg::PCM_CORE_RUN;
				end
			end
			default: begin
				core_state_nxt = pcm_pkg::CORE_STATE_RST;
			end
		endcase
	end

	// ============================================================
	// Peripheral enables
	// Set wins over clear when both arrive for the same peripheral
	assign periph_en_nxt = (periph_en_r & ~periph_clk_off_in) | periph_clk_on_in;

	// ============================================================
	// Registers
	// Reset returns the core to RUN, which restarts a stopped core clock
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			core_state_r <= pcm_pkg::CORE_STATE_RST;
		end else begin
			core_state_r <= core_state_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			periph_en_r <= {PERIPH_COUNT{pcm_pkg::PERIPH_CLK_EN_RST}};
		end else begin
			// No wait on peripheral activity: the gate follows next low phase
			periph_en_r <= periph_en_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			core_wake_r <= pcm_pkg::PULSE_RST;
		end else begin
			core_wake_r <= do_wake;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wake_cause_r <= '0;
		end else begin
			wake_cause_r <= wake_cause_nxt;
		end
	end

	// ============================================================
	// Status registers
	// Status copies the gate flops, not the enables, so it never
	// reports a clock that has not yet reached its output
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			core_running_r <= pcm_pkg::CORE_CLK_EN_RST;
		end else begin
			core_running_r <= core_gate_open;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			stop_pending_r <= pcm_pkg::PULSE_RST;
		end else begin
			stop_pending_r <= stop_pending_nxt;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			periph_running_r <= {PERIPH_COUNT{pcm_pkg::PERIPH_CLK_EN_RST}};
		end else begin
			periph_running_r <= periph_gate_open;
		end
	end

	// ============================================================
	// Clock gates
	// Gating only removes edges; no state behind a gate is reset or
	// touched, so a peripheral picks up where it left off

	// Core gate opens in reset so the core can fetch straight away
	pcm_clk_gate #(
		.EN_RST        (pcm_pkg::CORE_CLK_EN_RST)
	) u_core_gate (
		.clk_in        (core_clk_in),
		.rst_in        (rst_in),
		.enable_in     (core_gate_req),
		.gclk_out      (core_gclk_out),
		.gate_open_out (core_gate_open)
	);

	genvar gi;
	generate
		for (gi = 0; gi < PERIPH_COUNT; gi = gi + 1) begin : g_periph_gate
			pcm_clk_gate #(
				.EN_RST        (pcm_pkg::PERIPH_CLK_EN_RST)
			) u_periph_gate (
				.clk_in        (core_clk_in),
				.rst_in        (rst_in),
				.enable_in     (periph_en_r[gi]),
				.gclk_out      (periph_gclk_out[gi]),
				.gate_open_out (periph_gate_open[gi])
			);
		end
	endgenerate

	// ============================================================
	// Outputs
	// Status outputs are flops; the gated clocks are the AND gates above,
	// since a flop could not pass both edges of the source clock
	assign core_clk_running_out   = core_running_r;
	assign core_stop_pending_out  = stop_pending_r;
	assign core_wake_out          = core_wake_r;
	assign wake_cause_out         = wake_cause_r;
	assign periph_clk_running_out = periph_running_r;

endmodule : pcm_power_clock_manager

// ===== tb/pcm_manager_chk.sv
`timescale 1ns/1ps
// ==========
// Port checker
module pcm_manager_chk #(
	parameter int unsigned PERIPH_COUNT = pcm_pkg::PERIPH_COUNT,
	parameter int unsigned IRQ_COUNT    = pcm_pkg::IRQ_COUNT
) (
	input wire logic                    core_clk_in,
	input wire logic                    rst_in,
	input wire logic                    core_clk_off_in,
	input wire logic                    core_instr_done_in,
	input wire logic [IRQ_COUNT-1:0]    irq_req_in,
	input wire logic [IRQ_COUNT-1:0]    irq_enable_in,
	input wire logic [PERIPH_COUNT-1:0] periph_clk_on_in,
	input wire logic [PERIPH_COUNT-1:0] periph_clk_off_in,
	input wire logic                    core_gclk_out,
	input wire logic [PERIPH_COUNT-1:0] periph_gclk_out,
	input wire logic                    core_clk_running_out,
	input wire logic                    core_stop_pending_out,
	input wire logic                    core_wake_out,
	input wire logic [IRQ_COUNT-1:0]    wake_cause_out,
	input wire logic [PERIPH_COUNT-1:0] periph_clk_running_out
);
	logic [1:0]              st_r;
	logic [PERIPH_COUNT-1:0] pen_r;
	wire  [IRQ_COUNT-1:0]    hits_w = irq_req_in & irq_enable_in;
	wire                     run_w  = st_r != 2'h2;
	wire  [1:0]              st_nxt = (st_r == 2'h0) ? (core_clk_off_in ? (core_instr_done_in ? 2'h2 : 2'h1) : 2'h0) :
		(st_r == 2'h1) ? (core_instr_done_in ? 2'h2 : 2'h1) : ((|hits_w) ? 2'h0 : 2'h2);
	always_ff @(posedge core_clk_in) begin
		st_r  <= rst_in ? 2'h0 : st_nxt;
		pen_r <= rst_in ? '0 : (periph_clk_on_in | (pen_r & ~periph_clk_off_in));
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_drain_pending: assert property (core_stop_pending_out == (st_r == 2'h1)) else $error("pending wrong");
	a_drain_runs: assert property (st_r == 2'h1 |=> core_clk_running_out) else $error("stopped early");
	a_core_status: assert property (core_clk_running_out == $past(run_w)) else $error("core status");
	a_wake_pulse: assert property (core_wake_out == (st_r == 2'h0 && $past(st_r) == 2'h2)) else $error("wake");
	a_wake_cause: assert property (core_wake_out |-> wake_cause_out == $past(hits_w)) else $error("cause");
	a_core_gate: assert property (@(negedge core_clk_in) core_gclk_out == $past(run_w)) else $error("core gate");
	a_periph_status: assert property (periph_clk_running_out == $past(pen_r)) else $error("periph status");
	a_periph_gate: assert property (@(negedge core_clk_in) periph_gclk_out == $past(pen_r)) else $error("gate");
endmodule : pcm_manager_chk
bind pcm_power_clock_manager pcm_manager_chk #(.PERIPH_COUNT(PERIPH_COUNT), .IRQ_COUNT(IRQ_COUNT)) u_chk (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .core_clk_off_in(core_clk_off_in),
	.core_instr_done_in(core_instr_done_in), .irq_req_in(irq_req_in), .irq_enable_in(irq_enable_in),
	.periph_clk_on_in(periph_clk_on_in), .periph_clk_off_in(periph_clk_off_in), .core_gclk_out(core_gclk_out),
	.periph_gclk_out(periph_gclk_out), .core_clk_running_out(core_clk_running_out),
	.core_stop_pending_out(core_stop_pending_out), .core_wake_out(core_wake_out),
	.wake_cause_out(wake_cause_out), .periph_clk_running_out(periph_clk_running_out));

// ===== tb/pcm_far_model.sv
`timescale 1ns/1ps
// ==========
// Core and peripherals behind the gates
module pcm_far_model #(
	parameter int unsigned PERIPH_COUNT = pcm_pkg::PERIPH_COUNT
) (
	input  wire logic                          core_gclk_in,
	input  wire logic [PERIPH_COUNT-1:0]       periph_gclk_in,
	input  wire logic                          rst_in,
	input  wire logic                          slow_in,
	output      logic                          instr_done_out,
	output      logic [PERIPH_COUNT-1:0][15:0] periph_cnt_out
);
	logic [1:0]                    step_r = 2'h0;
	logic [PERIPH_COUNT-1:0][15:0] cnt_r  = '0;
	// Slow core retires every fourth gated cycle
	assign instr_done_out = !slow_in || step_r == 2'h3;
	assign periph_cnt_out = cnt_r;
	always @(posedge core_gclk_in) step_r <= rst_in ? 2'h0 : step_r + 2'h1;
	for (genvar i = 0; i < PERIPH_COUNT; i++) begin : g_per
		// Never cleared, so a stall shows as a gap only
		// The first edge out of a still unknown gate is not a real pulse
		always @(posedge periph_gclk_in[i]) if (periph_gclk_in[i]) cnt_r[i] <= cnt_r[i] + 16'h1;
	end
endmodule : pcm_far_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ==========
// Bench
module tb_top;
	logic            core_clk_in = 1'b0;
	logic            rst_in      = 1'b1;
	logic            off         = 1'b0;
	logic            slow        = 1'b0;
	logic [7:0]      irq         = 8'h00;
	logic [7:0]      en          = 8'h00;
	logic [7:0]      on          = 8'h00;
	logic [7:0]      poff        = 8'h00;
	logic [7:0]      pen         = 8'h00;
	wire             done, gclk, run, pend, wk;
	wire  [7:0]      pg, cause, prun;
	wire  [7:0][15:0] cnt;
	logic            e_run, e_pend, e_wk;
	logic [7:0]      e_cause, e_prun;
	int              st, cyc, num_errors, samples_checked, gc, ec;
	int              pc[8] = '{default: 0};
	pcm_power_clock_manager u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .core_clk_off_in(off),
		.core_instr_done_in(done), .irq_req_in(irq), .irq_enable_in(en), .periph_clk_on_in(on),
		.periph_clk_off_in(poff), .core_gclk_out(gclk), .periph_gclk_out(pg), .core_clk_running_out(run),
		.core_stop_pending_out(pend), .core_wake_out(wk), .wake_cause_out(cause), .periph_clk_running_out(prun));
	pcm_far_model u_far (.core_gclk_in(gclk), .periph_gclk_in(pg), .rst_in(rst_in), .slow_in(slow),
		.instr_done_out(done), .periph_cnt_out(cnt));
	initial forever #2.5 core_clk_in = ~core_clk_in;
	always @(posedge gclk) if (gclk && !rst_in) gc++;
	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : check
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic step(input int n, input logic wake);
		repeat (n) @(posedge core_clk_in) begin
			off  <= ($urandom % 6) == 0;
			on   <= 8'($urandom & $urandom);
			poff <= 8'($urandom & $urandom);
			irq  <= wake ? 8'($urandom & $urandom & $urandom) : 8'h00;
			en   <= 8'($urandom);
		end
	endtask : step
	always @(posedge core_clk_in) begin
		cyc++;
		// Gates reset on the falling edge, so the first reset edge has no pulse
		if (!rst_in) begin
			ec += int'(st != 2);
			for (int i = 0; i < 8; i++) pc[i] += pen[i];
		end
		e_wk = 1'b0;
		if (rst_in) begin
			{st, pen, e_run, e_pend, e_cause, e_prun} = {32'd0, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00};
		end else begin
			e_prun = pen;
			e_run  = st != 2;
			if (st == 0 && off) st = done ? 2 : 1;
			else if (st == 1 && done) st = 2;
			else if (st == 2 && |(irq & en)) begin
				st      = 0;
				e_wk    = 1'b1;
				e_cause = irq & en;
			end
			e_pend = st == 1;
			pen    = on | (pen & ~poff);
		end
		if (cyc > 3000) begin
			num_errors++;
			summarize();
		end
	end
	always @(negedge core_clk_in) if (!rst_in)
		check("status", {e_run, e_pend, e_wk, e_cause, e_prun}, {run, pend, wk, cause, prun});
	initial begin
		void'($urandom(32'h4C8BEFFF));
		repeat (12) @(posedge core_clk_in);
		rst_in <= 1'b0;
		step(400, 1'b1);
		slow <= 1'b1;
		step(400, 1'b1);
		// No wakes, so the core parks stopped before the mid-run reset
		step(100, 1'b0);
		rst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		step(200, 1'b1);
		@(negedge core_clk_in);
		for (int i = 0; i < 8; i++) check("periph count", pc[i], 32'(cnt[i]));
		check("core pulses", ec, gc);
		summarize();
	end
endmodule : tb_top
